// >>> ddc_pkg.sv
// Shared constants and types for the dual converter command decoder.
package ddc_pkg;
   localparam int WORD_W = 16;
   localparam int PAY_W = 12;
   localparam int CNT_W = 5;
   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam int SEL_HI_POS = 15;
   localparam int SPEED_POS = 14;
   localparam int POWER_DOWN_POS = 13;
   localparam int SEL_LO_POS = 12;
   localparam int VREF_HI_POS = 1;
   localparam int VREF_LO_POS = 0;
   localparam logic [11:0] CODE_RST = 12'h000;
   localparam logic [1:0] VREF_RST = 2'h0;
   localparam logic SPEED_RST = 1'b0;
   localparam logic POWER_DOWN_RST = 1'b0;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0]
   {
      TGT_B_AND_BUF = 2'b00,
      TGT_BUF = 2'b01,
      TGT_A_XFER = 2'b10,
      TGT_CTRL = 2'b11
   } ddc_target_t;

   typedef enum logic [1:0]
   {
      VREF_EXT0 = 2'b00,
      VREF_1V024 = 2'b01,
      VREF_2V048 = 2'b10,
      VREF_EXT3 = 2'b11
   } ddc_vref_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_FRAME = 2'b01,
      ST_APPLY = 2'b10
   } ddc_state_t;
endpackage

// >>> ddc_shifter.sv
// Serial-clock domain shifter that assembles command words.
`timescale 1ns/1ps
module ddc_shifter
   import ddc_pkg::*;
(
   input wire logic sclk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic din,
   output logic [ddc_pkg::WORD_W-1:0] shift_q,
   output logic [ddc_pkg::WORD_W-1:0] word_q,
   output logic [ddc_pkg::CNT_W-1:0] cnt_q,
   output logic done_tgl_q
);
   import ddc_pkg::*;

   logic ack_q;
   logic mark_q;
   logic had_bits_q;
   logic fresh;
   logic last_bit;
   logic [WORD_W-1:0] shift_d;
   logic [CNT_W-1:0] bit_cnt_q;
   logic [CNT_W-1:0] cnt_d;

   ////////////////////////////////////////////////////////////////////////
   // Each chip select rise closes a frame and notes whether it carried any bit.
   always_ff @(posedge cs_n or posedge rst)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
         had_bits_q <= 1'b0;
      end
      else
      begin
         ack_q <= mark_q;
         had_bits_q <= (mark_q != ack_q);
      end
   end

   // The first bit of a frame moves the mark away from the last closed frame.
   assign fresh = (mark_q == ack_q);
   assign shift_d = fresh ? {{(WORD_W-1){1'b0}}, din} : {shift_q[WORD_W-2:0], din};
   assign cnt_d = fresh ? 5'h01 : bit_cnt_q + 5'h01;
   assign last_bit = !fresh && (bit_cnt_q == WORD_BITS - 5'h01);
   // A frame without bits shows a zero count, so an old short word is not applied again.
   assign cnt_q = had_bits_q ? bit_cnt_q : '0;

   ////////////////////////////////////////////////////////////////////////
   // Bits enter MSB first on falling serial clock edges.
   always_ff @(negedge sclk or posedge rst)
   begin
      if (rst)
      begin
         mark_q <= 1'b0;
         shift_q <= '0;
         word_q <= '0;
         bit_cnt_q <= '0;
         done_tgl_q <= 1'b0;
      end
      else if (!cs_n && (fresh || bit_cnt_q != WORD_BITS))
      begin
         if (fresh)
            mark_q <= ~ack_q;
         shift_q <= shift_d;
         bit_cnt_q <= cnt_d;
         if (last_bit)
         begin
            word_q <= shift_d;
            done_tgl_q <= ~done_tgl_q;
         end
      end
   end
endmodule

// >>> ddc_top.sv
// Command decoder and output latches of the dual 12-bit converter.
`timescale 1ns/1ps
//
// Function
// - Word is four program bits, twelve payload.
// - Bit 14 selects fast or slow settling.
// - Bit 13 set forces power down.
// - Selector is bit 15 high, bit 12 low.
// - Selector 00 loads output B and buffer.
// - Selector 01 loads buffer only.
// - Selector 10 loads A, copies buffer to B.
// - Selector 11 writes the control register.
// - Code writes use all twelve payload bits.
// - Control writes use payload bits 1 and 0.
// - Reference 00/11 external, 01 1.024, 10 2.048.
// - Output changes right after sixteenth bit sampled; a short word at chip select rise.
// - Buffer then A word updates both together.
// - Control register survives converter writes.
// - Chip select frames MSB-first sixteen-bit shifts.
// - Reset clears every latch to zero.
module ddc_top
   import ddc_pkg::*;
#(
   parameter int SYNC_N = ddc_pkg::SYNC_STAGES
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic [ddc_pkg::PAY_W-1:0] output_a_code_q,
   output logic [ddc_pkg::PAY_W-1:0] output_b_code_q,
   output logic [ddc_pkg::PAY_W-1:0] holding_buffer_q,
   output logic [ddc_pkg::PAY_W-1:0] reference_control_q,
   output logic settle_speed_q,
   output logic power_down_q,
   output logic vref_external,
   output logic vref_1v024,
   output logic vref_2v048,
   output logic word_applied_q,
   output logic frame_active
);
   import ddc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Serial clock domain.
   logic [WORD_W-1:0] shift_q;
   logic [WORD_W-1:0] word_q;
   logic [CNT_W-1:0] cnt_q;
   logic done_tgl_q;

   ddc_shifter u_shifter
   (
      .sclk(sclk),
      .rst(rst),
      .cs_n(cs_n),
      .din(din),
      .shift_q(shift_q),
      .word_q(word_q),
      .cnt_q(cnt_q),
      .done_tgl_q(done_tgl_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Crossings into the reference clock domain.
   logic [SYNC_N-1:0] cs_sync_q;
   logic cs_seen_q;
   logic [SYNC_N-1:0] tgl_sync_q;
   logic tgl_seen_q;
   logic cs_n_s;
   logic tgl_s;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cs_sync_q <= '1;
         cs_seen_q <= 1'b1;
         tgl_sync_q <= '0;
         tgl_seen_q <= 1'b0;
      end
      else
      begin
         cs_sync_q <= {cs_sync_q[SYNC_N-2:0], cs_n};
         cs_seen_q <= cs_n_s;
         tgl_sync_q <= {tgl_sync_q[SYNC_N-2:0], done_tgl_q};
         tgl_seen_q <= tgl_s;
      end
   end

   assign cs_n_s = cs_sync_q[SYNC_N-1];
   assign tgl_s = tgl_sync_q[SYNC_N-1];

   ////////////////////////////////////////////////////////////////////////
   // Word events: a full word, or a short word ended by chip select.
   logic full_evt;
   logic cs_fall_evt;
   logic cs_rise_evt;
   logic short_word;
   logic short_evt;

   assign full_evt = tgl_s ^ tgl_seen_q;
   assign cs_fall_evt = cs_seen_q && !cs_n_s;
   assign cs_rise_evt = !cs_seen_q && cs_n_s;
   assign short_word = (cnt_q != '0) && (cnt_q != WORD_BITS);
   assign short_evt = cs_rise_evt && short_word;

   ////////////////////////////////////////////////////////////////////////
   // Frame tracking state machine.
   ddc_state_t state_q;
   ddc_state_t state_d;
   logic take_word;

   always_comb
   begin
      state_d = state_q;
      take_word = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (cs_fall_evt)
               state_d = ST_FRAME;
            if (full_evt)
            begin
               take_word = 1'b1;
               state_d = ST_APPLY;
            end
         end
         ST_FRAME:
         begin
            if (full_evt || short_evt)
            begin
               take_word = 1'b1;
               state_d = ST_APPLY;
            end
            else if (cs_rise_evt)
               state_d = ST_IDLE;
         end
         ST_APPLY:
         begin
            if (cs_n_s)
               state_d = ST_IDLE;
            else if (full_evt)
               take_word = 1'b1;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   assign frame_active = !cs_n_s;

   ////////////////////////////////////////////////////////////////////////
   // Field decode of the accepted word.
   logic [WORD_W-1:0] cmd;
   logic [PAY_W-1:0] payload;
   ddc_target_t target;
   logic [1:0] vref_field;

   // A short word is taken as shifted so far.
   assign cmd = short_evt ? shift_q : word_q;
   assign payload = cmd[PAY_W-1:0];
   assign target = ddc_target_t'({cmd[SEL_HI_POS], cmd[SEL_LO_POS]});
   assign vref_field = {payload[VREF_HI_POS], payload[VREF_LO_POS]};

   logic load_b_direct;
   logic load_buf;
   logic load_a;
   logic load_ctrl;

   assign load_b_direct = take_word && (target == TGT_B_AND_BUF);
   assign load_buf = take_word && (target == TGT_B_AND_BUF || target == TGT_BUF);
   assign load_a = take_word && (target == TGT_A_XFER);
   assign load_ctrl = take_word && (target == TGT_CTRL);

   ////////////////////////////////////////////////////////////////////////
   // Next values of the latches.
   logic [PAY_W-1:0] a_d;
   logic [PAY_W-1:0] b_d;
   logic [PAY_W-1:0] buf_d;
   logic [PAY_W-1:0] ctrl_d;
   logic speed_d;
   logic power_down_d;

   assign a_d = load_a ? payload : output_a_code_q;
   // Selector 10 moves the old buffer to B in the same edge as A.
   assign b_d = load_b_direct ? payload : (load_a ? holding_buffer_q : output_b_code_q);
   assign buf_d = load_buf ? payload : holding_buffer_q;
   // Only the reference field is kept; upper payload bits read as zero.
   assign ctrl_d = load_ctrl ? {{(PAY_W-2){1'b0}}, vref_field} : reference_control_q;
   assign speed_d = take_word ? cmd[SPEED_POS] : settle_speed_q;
   assign power_down_d = take_word ? cmd[POWER_DOWN_POS] : power_down_q;

   ////////////////////////////////////////////////////////////////////////
   // Latches update on the edge after the word event.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         output_a_code_q <= CODE_RST;
         output_b_code_q <= CODE_RST;
         holding_buffer_q <= CODE_RST;
         reference_control_q <= {{(PAY_W-2){1'b0}}, VREF_RST};
         settle_speed_q <= SPEED_RST;
         power_down_q <= POWER_DOWN_RST;
         word_applied_q <= 1'b0;
      end
      else
      begin
         output_a_code_q <= a_d;
         output_b_code_q <= b_d;
         holding_buffer_q <= buf_d;
         reference_control_q <= ctrl_d;
         settle_speed_q <= speed_d;
         power_down_q <= power_down_d;
         word_applied_q <= take_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference source decode; the host keeps external selected when it
   // drives the reference pin.
   ddc_vref_t vref_sel;

   assign vref_sel = ddc_vref_t'(reference_control_q[1:0]);
   assign vref_external = (vref_sel == VREF_EXT0) || (vref_sel == VREF_EXT3);
   assign vref_1v024 = (vref_sel == VREF_1V024);
   assign vref_2v048 = (vref_sel == VREF_2V048);
endmodule

// >>> ddc_host.sv
// Host serial port model that frames and shifts command words.
`timescale 1ns/1ps
module ddc_host
(
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Sends sixteen bits MSB first on falling clocks, then any ignored extras.
   // A negative extra count cuts the frame short by that many bits.
   task automatic send(input logic [15:0] w, input int extra);
      int i;
      #3.1 cs_n = 1'b0;
      for (i = 0; i < 16 + extra; i++)
      begin
         din = (i < 16) ? w[15-i] : ~din;
         #62.5 sclk = 1'b0;
         #62.5 sclk = 1'b1;
      end
      #20 cs_n = 1'b1;
      din = ~din;
      #100;
   endtask
endmodule

// >>> ddc_chk.sv
// Concurrent checks on the ports of the command decoder.
`timescale 1ns/1ps
module ddc_chk
   import ddc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [ddc_pkg::PAY_W-1:0] output_a_code_q,
   input wire logic [ddc_pkg::PAY_W-1:0] output_b_code_q,
   input wire logic [ddc_pkg::PAY_W-1:0] holding_buffer_q,
   input wire logic [ddc_pkg::PAY_W-1:0] reference_control_q,
   input wire logic vref_external,
   input wire logic vref_1v024,
   input wire logic vref_2v048,
   input wire logic word_applied_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_pulse;
      word_applied_q ##1 !word_applied_q;
   endsequence
   property p_pulse;
      $rose(word_applied_q) |-> s_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("apply pulse too long");
   property p_reset;
      $past(rst) |-> {output_a_code_q, output_b_code_q, holding_buffer_q} == 36'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("latch not cleared");
   property p_xfer;
      $changed(output_a_code_q) |-> word_applied_q && output_b_code_q == $past(holding_buffer_q);
   endproperty
   a_xfer: assert property (p_xfer) else $error("a write without b copy");
   property p_b_buf;
      $changed(output_b_code_q) |-> output_b_code_q == holding_buffer_q;
   endproperty
   a_b_buf: assert property (p_b_buf) else $error("b differs from buffer");
   property p_buf_only;
      $changed(holding_buffer_q) |-> $stable(output_a_code_q);
   endproperty
   a_buf_only: assert property (p_buf_only) else $error("buffer write moved a");
   property p_ctrl;
      $changed(reference_control_q) |-> $stable(output_a_code_q) && $stable(holding_buffer_q);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control write moved a code");
   property p_upper;
      reference_control_q[11:2] == 10'h000;
   endproperty
   a_upper: assert property (p_upper) else $error("control upper bits set");
   property p_vref;
      vref_external == (reference_control_q[1] == reference_control_q[0]) &&
      vref_1v024 == (reference_control_q[1:0] == 2'h1) &&
      vref_2v048 == (reference_control_q[1:0] == 2'h2);
   endproperty
   a_vref: assert property (p_vref) else $error("reference decode wrong");
endmodule
bind ddc_top ddc_chk chk (.ref_clk(ref_clk), .rst(rst), .output_a_code_q(output_a_code_q),
   .output_b_code_q(output_b_code_q), .holding_buffer_q(holding_buffer_q),
   .reference_control_q(reference_control_q), .vref_external(vref_external),
   .vref_1v024(vref_1v024), .vref_2v048(vref_2v048), .word_applied_q(word_applied_q));

// >>> test_ddc_top.sv
// Self-checking testbench for the dual converter command decoder.
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin total_checks++; if ((got) !== (exp)) begin fails++; \
   $display("Error %0t: got %h expected %h", $time, got, exp); end end
module test_ddc_top;
   import ddc_pkg::*;
   logic ref_clk, rst, sclk, cs_n, din, settle_speed_q, power_down_q, word_applied_q;
   logic vref_external, vref_1v024, vref_2v048, frame_active;
   logic [PAY_W-1:0] output_a_code_q, output_b_code_q, holding_buffer_q, reference_control_q;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   int applied = 0;
   ddc_host host (.cs_n(cs_n), .sclk(sclk), .din(din));
   ddc_top uut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
      .output_a_code_q(output_a_code_q), .output_b_code_q(output_b_code_q),
      .holding_buffer_q(holding_buffer_q), .reference_control_q(reference_control_q),
      .settle_speed_q(settle_speed_q), .power_down_q(power_down_q),
      .vref_external(vref_external), .vref_1v024(vref_1v024), .vref_2v048(vref_2v048),
      .word_applied_q(word_applied_q), .frame_active(frame_active));
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (fails == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         report_and_stop();
      end
   end
   always @(negedge ref_clk)
   begin
      if (word_applied_q === 1'b1)
         applied++;
   end
   task automatic t_reset();
      `CHK(({output_a_code_q, output_b_code_q, holding_buffer_q, word_applied_q}), 37'h0)
      `CHK(frame_active, 1'b0)
      `CHK(({reference_control_q, settle_speed_q, power_down_q, vref_external}), 15'h1)
   endtask
   task automatic t_ctrl();
      int r;
      logic [2:0] vexp;
      for (r = 0; r < 4; r++)
      begin
         host.send({4'hd, 10'h3ff, 2'(r)}, 0);
         vexp = (r == 1) ? 3'h2 : (r == 2) ? 3'h4 : 3'h1;
         `CHK(reference_control_q, {10'h000, 2'(r)})
         `CHK(({vref_2v048, vref_1v024, vref_external}), vexp)
         `CHK(({settle_speed_q, output_a_code_q}), 13'h1000)
      end
   endtask
   task automatic t_buf();
      host.send(16'h3abc, 0);
      `CHK(({holding_buffer_q, output_a_code_q, output_b_code_q}), 36'habc000000)
      `CHK(({power_down_q, settle_speed_q}), 2'h2)
   endtask
   task automatic t_xfer();
      fork
         host.send(16'h85a5, 1);
         begin
            #1000;
            @(negedge ref_clk);
            `CHK(frame_active, 1'b1)
         end
      join
      `CHK(frame_active, 1'b0)
      `CHK(({output_a_code_q, output_b_code_q}), 24'h5a5abc)
      `CHK(({power_down_q, reference_control_q}), 13'h0003)
   endtask
   task automatic t_b();
      host.send(16'h4fff, 0);
      `CHK(({output_b_code_q, holding_buffer_q, output_a_code_q}), 36'hffffff5a5)
      `CHK(({settle_speed_q, reference_control_q}), 13'h1003)
   endtask
   task automatic t_short();
      int n;
      n = applied;
      host.send(16'habc0, -4);
      `CHK(({output_b_code_q, holding_buffer_q, settle_speed_q, power_down_q}), 26'h2af2af0)
      `CHK(({output_a_code_q, reference_control_q}), 24'h5a5003)
      host.send(16'hffff, -16);
      `CHK(applied, n + 1)
   endtask
   initial
   begin
      rst = 1'b1;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      repeat (3) @(negedge ref_clk);
      t_reset();
      t_ctrl();
      t_buf();
      t_xfer();
      t_b();
      t_short();
      @(negedge ref_clk);
      rst = 1'b1;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      repeat (3) @(negedge ref_clk);
      t_reset();
      report_and_stop();
   end
endmodule
